// ==== qaw_pkg.sv ====
// Package of register indices, field layouts, reset values and timing counts for the query-answer watchdog.
package qaw_pkg;

  // ----------------------------------------------------------------
  // Register indices on the decoded register access port
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CHALLENGE = 3'h0; // Read: challenge_readout, write: response_entry.
  localparam logic [2:0] REG_RESP_WIN = 3'h1;
  localparam logic [2:0] REG_REQ_WIN = 3'h2;
  localparam logic [2:0] REG_COUNTER = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WIN_START_LSB = 0;   // 8-bit window start.
  localparam int WIN_END_LSB = 8;     // 6-bit end delta.
  localparam int WIN_TO_LSB = 14;     // 6-bit timeout delta.
  localparam int CFG_BAD_LSB = 0;     // 3-bit bad_event_step.
  localparam int CFG_GOOD_LSB = 3;    // 3-bit good_event_step.
  localparam int CFG_THH_LSB = 6;     // 4-bit driver_enable_threshold.
  localparam int CFG_THL_LSB = 10;    // 4-bit driver_inhibit_threshold.
  localparam int CFG_DIV_BIT = 14;
  localparam int CFG_TORST_BIT = 15;
  localparam int CFG_REQCHK_BIT = 16;
  localparam int CFG_RSTEN_BIT = 17;
  localparam int RESP_LOW_LSB = 0;
  localparam int RESP_HIGH_LSB = 8;
  localparam int ST_CNT_LSB = 0;      // 4-bit counter_value_field.
  localparam int ST_FLAG_LSB = 4;     // Eight sticky flags, bits 11:4.
  localparam int ST_TALLY_LSB = 12;   // 4-bit reset_event_tally.

  // Flag order inside the eight sticky flag bits.
  localparam int F_EARLY_RESP = 0;
  localparam int F_LATE_RESP = 1;
  localparam int F_WRONG_RESP = 2;
  localparam int F_EARLY_REQ = 3;
  localparam int F_LATE_REQ = 4;
  localparam int F_RESP_TO = 5;
  localparam int F_REQ_TO = 6;
  localparam int F_ZERO_CNT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_WIN_START = 8'hFF;
  localparam logic [5:0] RST_WIN_END = 6'h30;
  localparam logic [5:0] RST_WIN_TO = 6'h00;
  localparam logic [2:0] RST_GOOD_STEP = 3'h1;
  localparam logic [2:0] RST_BAD_STEP = 3'h3;
  localparam logic [3:0] RST_TH_LOW = 4'h7;
  localparam logic [3:0] RST_TH_HIGH = 4'hF;
  localparam logic RST_RST_EN = 1'b1;
  localparam logic RST_REQ_CHECK = 1'b0;
  localparam logic RST_TO_RST_EN = 1'b0;
  localparam logic RST_DIV_SEL = 1'b0;
  localparam logic [3:0] RST_COUNTER = 4'h7;
  localparam logic [6:0] LFSR_SEED = 7'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_TICK_NS = 4000;                       // 250 kHz base tick.
  localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int FINE_TICK_US = 64;
  localparam int COARSE_TICK_US = 256;
  localparam int FINE_DIV = FINE_TICK_US * 1000 / BASE_TICK_NS;
  localparam int COARSE_DIV = COARSE_TICK_US * 1000 / BASE_TICK_NS;

  typedef enum logic [1:0] {QAW_IDLE, QAW_WAIT_RESP, QAW_WAIT_REQ} qaw_state_type;

endpackage

// ==== qaw_query_answer_watchdog.sv ====
// Query-and-answer watchdog core with its configuration and status registers.
`timescale 1ns/1ps
module qaw_query_answer_watchdog
#(
  parameter int unsigned RST_PULSE_CYCLES = 80
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] reg_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic pulse_frequency_supervisor,
  output logic [31:0] reg_rdata,
  output logic supervisor_reset_out,
  output logic driver_enable
);
  import qaw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  qaw_state_type state_reg;
  qaw_state_type state_next;
  logic [7:0] resp_start_reg;
  logic [5:0] resp_end_reg;
  logic [5:0] resp_to_reg;
  logic [7:0] req_start_reg;
  logic [5:0] req_end_reg;
  logic [5:0] req_to_reg;
  logic [2:0] good_event_step;
  logic [2:0] bad_event_step;
  logic [3:0] driver_inhibit_threshold;
  logic [3:0] driver_enable_threshold;
  logic reset_on_zero_enable;
  logic request_timing_check_enable;
  logic timeout_reset_enable;
  logic tick_divider_select;
  logic [3:0] error_event_counter;
  logic [3:0] cnt_next;
  logic [3:0] reset_event_tally;
  logic [7:0] flags_reg;
  logic [7:0] flag_set;
  logic [6:0] lfsr_reg;
  logic [7:0] challenge_field;
  logic [9:0] timer_reg;
  logic [6:0] base_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic base_tick;
  logic window_tick;
  logic [31:0] pulse_cnt_reg;
  logic ev_good;
  logic ev_bad;
  logic timer_clear;
  logic advance;
  logic to_evt;
  logic to_is_resp;
  logic zero_evt;
  logic qa_supervisor_reset;
  logic cfg_wr_ok;
  logic chal_rd;
  logic chal_wr;
  logic [9:0] win_lo;
  logic [9:0] win_hi;
  logic [9:0] win_to;
  logic [15:0] expected;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Saturating step so the counter never wraps past 0 or 15.
  function automatic logic [3:0] step_cnt(input logic [3:0] cnt, input logic up, input logic [2:0] step);
    logic [4:0] sum;
    sum = 5'h00;
    if (up)
    begin
      sum = {1'b0, cnt} + {2'b00, step};
      step_cnt = sum[4] ? 4'hF : sum[3:0];
    end
    else
    begin
      step_cnt = (cnt < {1'b0, step}) ? 4'h0 : cnt - {1'b0, step};
    end
  endfunction

  // Cumulative window end in ticks: start plus delta.
  function automatic logic [9:0] add_delta(input logic [9:0] base, input logic [5:0] delta);
    add_delta = base + {4'h0, delta};
  endfunction

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  // Base tick every 4 us, then 16 or 64 base ticks per window tick.
  assign base_tick = (base_cnt_reg == 7'(BASE_TICK_CYCLES - 1));
  assign window_tick = base_tick && (tick_divider_select ? (div_cnt_reg == 6'(COARSE_DIV - 1))
                                                         : (div_cnt_reg >= 6'(FINE_DIV - 1)));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_cnt_reg <= 7'h00;
      div_cnt_reg <= 6'h00;
    end
    else if (clk_en)
    begin
      base_cnt_reg <= base_tick ? 7'h00 : base_cnt_reg + 7'h01;
      if (window_tick)
        div_cnt_reg <= 6'h00;
      else if (base_tick)
        div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign chal_rd = reg_rd && (reg_sel == REG_CHALLENGE);
  assign chal_wr = reg_wr && (reg_sel == REG_CHALLENGE) && !chal_rd;
  assign challenge_field = {1'b0, lfsr_reg};
  assign expected = {challenge_field, 8'(-challenge_field)};
  assign cfg_wr_ok = reg_wr && (state_reg == QAW_IDLE);

  // Window limits of whichever window is running now.
  always_comb
  begin
    if (state_reg == QAW_WAIT_REQ)
    begin
      win_lo = {2'b00, req_start_reg};
      win_hi = add_delta(win_lo, req_end_reg);
      win_to = add_delta(win_hi, req_to_reg) + 10'h001;
    end
    else
    begin
      win_lo = {2'b00, resp_start_reg};
      win_hi = add_delta(win_lo, resp_end_reg);
      win_to = add_delta(win_hi, resp_to_reg) + 10'h001;
    end
  end

  // Sequence checker; a challenge read or response write takes priority over a timeout tick in the same cycle.
  always_comb
  begin
    state_next = state_reg;
    timer_clear = 1'b0;
    ev_good = 1'b0;
    ev_bad = 1'b0;
    advance = 1'b0;
    to_evt = 1'b0;
    to_is_resp = 1'b0;
    flag_set = 8'h00;
    if (chal_rd)
    begin
      timer_clear = 1'b1;
      state_next = QAW_WAIT_RESP;
      if (state_reg == QAW_WAIT_RESP)
        ev_bad = 1'b1;
      else if (state_reg == QAW_WAIT_REQ && request_timing_check_enable)
      begin
        if (timer_reg < win_lo)
        begin
          ev_bad = 1'b1;
          flag_set[F_EARLY_REQ] = 1'b1;
        end
        else if (timer_reg > win_hi)
        begin
          ev_bad = 1'b1;
          flag_set[F_LATE_REQ] = 1'b1;
        end
        else
          ev_good = 1'b1;
      end
    end
    else if (chal_wr)
    begin
      if (state_reg == QAW_WAIT_REQ)
        ev_bad = 1'b1;
      else if (state_reg == QAW_WAIT_RESP)
      begin
        timer_clear = 1'b1;
        state_next = QAW_WAIT_REQ;
        if (timer_reg < win_lo)
        begin
          ev_bad = 1'b1;
          flag_set[F_EARLY_RESP] = 1'b1;
        end
        else if (timer_reg > win_hi)
        begin
          ev_bad = 1'b1;
          flag_set[F_LATE_RESP] = 1'b1;
        end
        else if (reg_wdata[RESP_HIGH_LSB +: 8] != expected[15:8] || reg_wdata[RESP_LOW_LSB +: 8] != expected[7:0])
        begin
          ev_bad = 1'b1;
          flag_set[F_WRONG_RESP] = 1'b1;
        end
        else
        begin
          ev_good = 1'b1;
          advance = 1'b1;
        end
      end
    end
    else if (window_tick && state_reg != QAW_IDLE && timer_reg >= win_to)
    begin
      to_evt = 1'b1;
      to_is_resp = (state_reg == QAW_WAIT_RESP);
      timer_clear = 1'b1;
      if (!timeout_reset_enable)
        ev_bad = 1'b1;
      else if (to_is_resp)
        flag_set[F_RESP_TO] = 1'b1;
      else
        flag_set[F_REQ_TO] = 1'b1;
    end
  end

  // Counter update and the two reset causes.
  assign cnt_next = ev_good ? step_cnt(error_event_counter, 1'b1, good_event_step)
                  : ev_bad ? step_cnt(error_event_counter, 1'b0, bad_event_step) : error_event_counter;
  assign zero_evt = (error_event_counter != 4'h0) && (cnt_next == 4'h0);
  assign qa_supervisor_reset = (to_evt && timeout_reset_enable) || (zero_evt && reset_on_zero_enable);

  // ----------------------------------------------------------------
  // Sequencer state, timer and challenge generator
  // ----------------------------------------------------------------
  // The timer saturates so a very long stall cannot wrap back into the window.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= QAW_IDLE;
      timer_reg <= 10'h000;
    end
    else if (clk_en)
    begin
      state_reg <= (qa_supervisor_reset || pulse_frequency_supervisor) ? QAW_IDLE : state_next;
      if (timer_clear || state_next == QAW_IDLE || qa_supervisor_reset || pulse_frequency_supervisor)
        timer_reg <= 10'h000;
      else if (window_tick && timer_reg != 10'h3FF)
        timer_reg <= timer_reg + 10'h001;
    end
  end

  // Seven-bit Fibonacci LFSR, taps 7 and 6, maximal length 127.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_reg <= LFSR_SEED;
    else if (clk_en && advance)
      lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
  end

  // ----------------------------------------------------------------
  // Event counter, tally and driver enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      error_event_counter <= RST_COUNTER;
      reset_event_tally <= 4'h0;
    end
    else if (clk_en)
    begin
      error_event_counter <= cnt_next;
      if (qa_supervisor_reset && reset_event_tally != 4'hF)
        reset_event_tally <= reset_event_tally + 4'h1;
    end
  end

  // Hysteresis keeps drivers steady while the count wanders between thresholds.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      driver_enable <= 1'b0;
    else if (clk_en)
    begin
      if (error_event_counter < driver_inhibit_threshold)
        driver_enable <= 1'b0;
      else if (error_event_counter >= driver_enable_threshold)
        driver_enable <= 1'b1;
    end
  end

  // Reset output is stretched so the microcontroller sees a usable pulse.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_cnt_reg <= 32'h0000_0000;
      supervisor_reset_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (qa_supervisor_reset)
      begin
        pulse_cnt_reg <= RST_PULSE_CYCLES;
        supervisor_reset_out <= 1'b1;
      end
      else if (pulse_cnt_reg > 32'h0000_0001)
        pulse_cnt_reg <= pulse_cnt_reg - 32'h0000_0001;
      else
      begin
        pulse_cnt_reg <= 32'h0000_0000;
        supervisor_reset_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Only the power-state reset restores defaults; watchdog resets leave them alone.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_start_reg <= RST_WIN_START;
      resp_end_reg <= RST_WIN_END;
      resp_to_reg <= RST_WIN_TO;
      req_start_reg <= RST_WIN_START;
      req_end_reg <= RST_WIN_END;
      req_to_reg <= RST_WIN_TO;
      good_event_step <= RST_GOOD_STEP;
      bad_event_step <= RST_BAD_STEP;
      driver_inhibit_threshold <= RST_TH_LOW;
      driver_enable_threshold <= RST_TH_HIGH;
      reset_on_zero_enable <= RST_RST_EN;
      request_timing_check_enable <= RST_REQ_CHECK;
      timeout_reset_enable <= RST_TO_RST_EN;
      tick_divider_select <= RST_DIV_SEL;
    end
    else if (clk_en && cfg_wr_ok)
    begin
      if (reg_sel == REG_RESP_WIN)
      begin
        resp_start_reg <= reg_wdata[WIN_START_LSB +: 8];
        resp_end_reg <= reg_wdata[WIN_END_LSB +: 6];
        resp_to_reg <= reg_wdata[WIN_TO_LSB +: 6];
      end
      else if (reg_sel == REG_REQ_WIN)
      begin
        req_start_reg <= reg_wdata[WIN_START_LSB +: 8];
        req_end_reg <= reg_wdata[WIN_END_LSB +: 6];
        req_to_reg <= reg_wdata[WIN_TO_LSB +: 6];
      end
      else if (reg_sel == REG_COUNTER)
      begin
        bad_event_step <= reg_wdata[CFG_BAD_LSB +: 3];
        good_event_step <= reg_wdata[CFG_GOOD_LSB +: 3];
        driver_enable_threshold <= reg_wdata[CFG_THH_LSB +: 4];
        driver_inhibit_threshold <= reg_wdata[CFG_THL_LSB +: 4];
        tick_divider_select <= reg_wdata[CFG_DIV_BIT];
        timeout_reset_enable <= reg_wdata[CFG_TORST_BIT];
        request_timing_check_enable <= reg_wdata[CFG_REQCHK_BIT];
        reset_on_zero_enable <= reg_wdata[CFG_RSTEN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags and read data
  // ----------------------------------------------------------------
  // A flag raised in the same cycle as the clearing read survives.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= 8'h00;
    else if (clk_en)
    begin
      if (reg_rd && reg_sel == REG_STATUS)
        flags_reg <= flag_set;
      else
        flags_reg <= flags_reg | flag_set;
      if (zero_evt)
        flags_reg[F_ZERO_CNT] <= 1'b1;
    end
  end

  // Read data is registered and valid the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en && (reg_rd || chal_wr))
    begin
      if (reg_sel == REG_CHALLENGE)
        reg_rdata <= {24'h00_0000, advance ? {1'b0, lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]}
                                           : challenge_field};
      else if (reg_sel == REG_RESP_WIN)
        reg_rdata <= {12'h000, resp_to_reg, resp_end_reg, resp_start_reg};
      else if (reg_sel == REG_REQ_WIN)
        reg_rdata <= {12'h000, req_to_reg, req_end_reg, req_start_reg};
      else if (reg_sel == REG_COUNTER)
        reg_rdata <= {14'h0000, reset_on_zero_enable, request_timing_check_enable, timeout_reset_enable,
                      tick_divider_select, driver_inhibit_threshold, driver_enable_threshold,
                      good_event_step, bad_event_step};
      else if (reg_sel == REG_STATUS)
        reg_rdata <= {16'h0000, reset_event_tally, flags_reg, error_event_counter};
      else
        reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ==== qaw_watchdog_checker.sv ====
// Port-level assertions for the query-answer watchdog, bound to its top module.
`timescale 1ns/1ps
module qaw_watchdog_checker
#(
  parameter int unsigned RST_PULSE_CYCLES = 80
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [2:0] reg_sel,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic pulse_frequency_supervisor,
  input wire logic [31:0] reg_rdata,
  input wire logic supervisor_reset_out,
  input wire logic driver_enable
);
  import qaw_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------
  // Helper state
  // ----------
  int unsigned hi_cnt;
  logic [7:0] ch_last;
  logic ch_ok, rd_d, fresh, ch_rd, ch_wr;
  assign ch_rd = clk_en && reg_rd && reg_sel == REG_CHALLENGE;
  assign ch_wr = clk_en && reg_wr && reg_sel == REG_CHALLENGE;
  // Pulse length, last challenge read, and whether the sequencer was never started.
  // The never-started flag is set again only at power reset, so it under-reports on purpose.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_cnt <= 0;
      ch_last <= 8'h00;
      ch_ok <= 1'b0;
      rd_d <= 1'b0;
      fresh <= 1'b1;
    end
    else
    begin
      hi_cnt <= supervisor_reset_out ? hi_cnt + 1 : 0;
      rd_d <= ch_rd;
      ch_last <= rd_d ? reg_rdata[7:0] : ch_last;
      ch_ok <= (ch_ok || rd_d) && !ch_wr;
      fresh <= fresh && !ch_rd;
    end
  end
  // ----------
  // Assertions
  // ----------
  a_pulse_length: assert property ($fell(supervisor_reset_out) |-> hi_cnt == RST_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  a_rdata_holds: assert property (!(clk_en && (reg_rd || ch_wr)) |=> $stable(reg_rdata))
    else $error("read data moved without access");
  a_challenge_msb: assert property (ch_rd || ch_wr |=> reg_rdata[7] == 1'b0)
    else $error("challenge top bit set");
  a_unmapped_zero: assert property (clk_en && reg_rd && reg_sel > REG_STATUS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_zero_drivers_off: assert property (clk_en && reg_rd && reg_sel == REG_STATUS
    |=> reg_rdata[3:0] != 4'h0 || !driver_enable)
    else $error("drivers on at zero count");
  a_full_drivers_on: assert property (clk_en && reg_rd && reg_sel == REG_STATUS
    |=> reg_rdata[3:0] != 4'hF || driver_enable)
    else $error("drivers off at full count");
  a_challenge_repeat: assert property (ch_rd && ch_ok && !rd_d && !ch_wr |=> reg_rdata[7:0] == ch_last)
    else $error("challenge changed without answer");
  a_cfg_readback: assert property (fresh && clk_en && reg_wr && !reg_rd && reg_sel == REG_RESP_WIN ##2
    clk_en && reg_rd && reg_sel == REG_RESP_WIN |=> reg_rdata[19:0] == $past(reg_wdata[19:0], 3))
    else $error("window write before start lost");
  c_reset_pulse: cover property ($rose(supervisor_reset_out));
  c_drivers_on: cover property ($rose(driver_enable));
  c_challenge: cover property (ch_rd);
endmodule

bind qaw_query_answer_watchdog qaw_watchdog_checker #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) i_checker
(
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .pulse_frequency_supervisor(pulse_frequency_supervisor), .reg_rdata(reg_rdata),
  .supervisor_reset_out(supervisor_reset_out), .driver_enable(driver_enable)
);

// ==== qaw_mcu_model.sv ====
// Microcontroller model that reaches the watchdog registers and derives answers.
`timescale 1ns/1ps
module qaw_mcu_model
(
  input wire logic clk,
  input wire logic [31:0] reg_rdata,
  output logic [2:0] reg_sel,
  output logic reg_rd,
  output logic reg_wr,
  output logic [31:0] reg_wdata
);
  import qaw_pkg::*;
  // Bus starts quiet.
  initial
  begin
    reg_sel = 3'h0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // One access: strobe held for one edge, answer taken after it.
  // Idle lines show the inverse of the last request so stale values cannot pass.
  task automatic xfer(input logic rd, input logic [2:0] sel, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk);
    #2;
    reg_sel = sel;
    reg_rd = rd;
    reg_wr = !rd;
    reg_wdata = wd;
    @(posedge clk);
    #2;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_sel = ~sel;
    reg_wdata = ~wd;
    rdat = reg_rdata;
  endtask
  // Answer high byte is the challenge, low byte its negation; a fault flips bit 0.
  task automatic answer(input logic [7:0] ch, input logic bad, output logic [31:0] rdat);
    logic [7:0] neg;
    neg = 8'h00 - ch;
    xfer(1'b0, REG_CHALLENGE, {16'h0000, ch, neg ^ {7'h00, bad}}, rdat);
  endtask
endmodule

// ==== tb.sv ====
// Self-checking testbench for the query-answer watchdog.
`timescale 1ns/1ps
module tb;
  import qaw_pkg::*;
  // ----------
  // Signals
  // ----------
  localparam int PULSE = 4;
  localparam logic [31:0] CFG = 32'h0002_1253;
  logic clk, rst_n, pfs, reg_rd, reg_wr, supervisor_reset_out, driver_enable;
  logic [2:0] reg_sel;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [7:0] ch;
  int err_total, n_tests;
  // A short reset pulse keeps the run brief.
  qaw_query_answer_watchdog #(.RST_PULSE_CYCLES(PULSE)) i_dut
  (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .pulse_frequency_supervisor(pfs), .reg_rdata(reg_rdata),
    .supervisor_reset_out(supervisor_reset_out), .driver_enable(driver_enable)
  );
  qaw_mcu_model i_mcu
  (
    .clk(clk), .reg_rdata(reg_rdata), .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata)
  );
  // Clock at 20 MHz.
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // ----------
  // Tasks
  // ----------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read and compare only the low 8, 16 or 20 bits of each register.
  task automatic rdc(input logic [2:0] sel, input string what, input logic [31:0] exp);
    logic [31:0] m;
    m = sel == REG_STATUS ? 32'h0000_FFFF : (sel == REG_CHALLENGE ? 32'h0000_00FF : 32'h000F_FFFF);
    i_mcu.xfer(1'b1, sel, 32'h0000_0000, rv);
    check(what, exp, rv & m);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [31:0] wd);
    i_mcu.xfer(1'b0, sel, wd, rv);
  endtask
  task automatic ans(input logic bad, input logic [7:0] exp);
    i_mcu.answer(ch, bad, rv);
    check("answer_echo", {24'h0, exp}, rv & 32'h0000_00FF);
  endtask
  // Shift left with feedback from the two top bits of the seven.
  function automatic logic [7:0] next_ch(input logic [7:0] c);
    return {1'b0, c[5:0], c[6] ^ c[5]};
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for a reset pulse, then for its end.
  task automatic wait_pulse(input int bound);
    int i;
    i = 0;
    while (supervisor_reset_out !== 1'b1 && i < bound)
    begin
      @(posedge clk);
      #2;
      i++;
    end
    check("reset_pulse", 32'h1, {31'h0, supervisor_reset_out});
    if (supervisor_reset_out !== 1'b1)
      wrap_up();
    repeat (PULSE + 1) @(posedge clk);
    #2;
    check("reset_end", 32'h0, {31'h0, supervisor_reset_out});
  endtask
  // ----------
  // Main sequence
  // ----------
  initial
  begin
    err_total = 0;
    n_tests = 0;
    rst_n = 1'b0;
    pfs = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    rdc(REG_RESP_WIN, "resp_win", 32'h0000_30FF);
    rdc(REG_REQ_WIN, "req_win", 32'h0000_30FF);
    rdc(REG_COUNTER, "cnt_cfg", 32'h0002_1FCB);
    rdc(REG_STATUS, "status", 32'h0000_0007);
    rdc(3'h7, "unmapped", 32'h0000_0000);
    check("drv", 32'h0, {31'h0, driver_enable});
    wr(REG_RESP_WIN, 32'h0000_0300);
    rdc(REG_RESP_WIN, "resp_win", 32'h0000_0300);
    wr(REG_REQ_WIN, 32'h0000_0300);
    wr(REG_COUNTER, CFG);
    rdc(REG_COUNTER, "cnt_cfg", CFG);
    ch = {1'b0, LFSR_SEED};
    rdc(REG_CHALLENGE, "challenge", {24'h0, ch});
    wr(REG_RESP_WIN, 32'h0000_00FF);
    rdc(REG_RESP_WIN, "locked_win", 32'h0000_0300);
    ans(1'b0, next_ch(ch));
    ch = next_ch(ch);
    rdc(REG_STATUS, "status", 32'h0000_0009);
    check("drv", 32'h1, {31'h0, driver_enable});
    rdc(REG_CHALLENGE, "challenge", {24'h0, ch});
    rdc(REG_CHALLENGE, "repeat_req", {24'h0, ch});
    rdc(REG_STATUS, "status", 32'h0000_0006);
    check("drv", 32'h1, {31'h0, driver_enable});
    ans(1'b1, ch);
    rdc(REG_STATUS, "status", 32'h0000_0043);
    check("drv", 32'h0, {31'h0, driver_enable});
    ans(1'b0, ch);
    wait_pulse(20);
    rdc(REG_STATUS, "status", 32'h0000_1800);
    rdc(REG_STATUS, "status", 32'h0000_1000);
    rdc(REG_COUNTER, "cnt_cfg", CFG);
    wr(REG_COUNTER, CFG | 32'h0000_8000);
    rdc(REG_COUNTER, "cnt_cfg", CFG | 32'h0000_8000);
    rdc(REG_CHALLENGE, "challenge", {24'h0, ch});
    wait_pulse(8000);
    rdc(REG_STATUS, "status", 32'h0000_2200);
    rdc(REG_CHALLENGE, "challenge", {24'h0, ch});
    pfs = 1'b1;
    @(posedge clk);
    #2;
    pfs = 1'b0;
    wr(REG_RESP_WIN, 32'h0000_0305);
    rdc(REG_RESP_WIN, "resp_win", 32'h0000_0305);
    // An answer long before the window opens is early, and the count stays pinned at zero.
    wr(REG_COUNTER, CFG | 32'h0001_8000);
    rdc(REG_CHALLENGE, "challenge", {24'h0, ch});
    ans(1'b0, ch);
    rdc(REG_STATUS, "status", 32'h0000_2010);
    rdc(REG_CHALLENGE, "challenge", {24'h0, ch});
    rdc(REG_STATUS, "status", 32'h0000_2002);
    wrap_up();
  end
endmodule
